// ==== core/pmu_regbank.v ====
// Control register bank with two-wire slave, start-up sequencer and thermal flags.
`timescale 1ns/1ns
`include "pmu_consts.vh"

// What this block does
// [R1] Buck code zero picks external divider, else 0.80V plus 0.05V steps.
// [R2] Start-up delay code 0 to 6 gives that many time steps.
// [R3] Delay code 7 keeps the output off through start-up; in idle its enable bit turns it on.
// [R4] Forced-switching bit holds the buck in PWM, else automatic mode.
// [R5] In standby an enable bit chooses whether the next start-up turns it on.
// [R6] In idle an enable bit turns its regulator on or off at once.
// [R7] Sleep request bit acts only while pin sleep select is 0.
// [R8] Voltage select bit picks code a or b when pin select is 0.
// [R9] Each of six discharge bits switches that output's pull-down.
// [R10] After thermal shutdown, cooled and enabled, start-up runs by itself.
// [R11] Before that restart, retain bit 0 restores all registers to defaults.
// [R12] Status shows the shutdown flag live.
// [R13] Status shows the early-warning flag live.
// [R14] Interrupt register holds a shutdown interrupt bit.
// [R15] Interrupt register holds an early-warning interrupt bit.
// [R16] Every read of the interrupt register clears it after the byte goes out.
// [R17] Reading the interrupt register releases the interrupt pin.
// [R18] Time step is 25 us with short step set, else 50 us.
// [R19] A mask bit of 1 keeps its source off the interrupt pin.
// [R20] Interrupt bits set on rising events and hold until read.
// [R21] Writes to status, interrupt and reserved bits are ignored.
module pmu_regbank (
  input  wire       clock,
  input  wire       rst,
  input  wire       scl,
  input  wire       sda_i,
  output reg        sda_o,
  output reg        sda_oe,
  input  wire       en_pin,
  input  wire       dvs_pin,
  input  wire       temp_shutdown,
  input  wire       temp_warning,
  output reg        irq_n,
  output reg  [4:0] buck_voltage_code,
  output reg        buck_feedback_external,
  output reg        buck_forced_pwm,
  output reg        sleep_active,
  output reg  [5:0] output_on,
  output reg  [5:0] discharge_on
);

  // Bus phases.
  localparam [2:0] B_IDLE = 3'd0;
  localparam [2:0] B_RX   = 3'd1;
  localparam [2:0] B_RACK = 3'd2;
  localparam [2:0] B_TX   = 3'd3;
  localparam [2:0] B_TACK = 3'd4;
  // Kinds of received byte.
  localparam [1:0] K_ADDR = 2'd0;
  localparam [1:0] K_PTR  = 2'd1;
  localparam [1:0] K_DATA = 2'd2;
  // Power states.
  localparam [1:0] P_STBY  = 2'd0;
  localparam [1:0] P_START = 2'd1;
  localparam [1:0] P_IDLE  = 2'd2;
  localparam [1:0] P_HOT   = 2'd3;

  // Separate two-flop chains for the bus lines, which idle high.
  reg [1:0] scl_sync_q;
  reg [1:0] sda_sync_q;

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      scl_sync_q <= 2'b11;
      sda_sync_q <= 2'b11;
    end else begin
      scl_sync_q <= {scl_sync_q[0], scl};
      sda_sync_q <= {sda_sync_q[0], sda_i};
    end
  end

  wire scl_s    = scl_sync_q[1];
  wire sda_s    = sda_sync_q[1];

  // Two-flop synchronisers for the other pins, and previous values for edge finding.
  reg [4:1] sync1_q;
  reg [4:1] sync2_q;
  reg       scl_p_q;
  reg       sda_p_q;
  reg       hot_p_q;
  reg       warn_p_q;

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      sync1_q  <= 4'h0;
      sync2_q  <= 4'h0;
      scl_p_q  <= 1'b1;
      sda_p_q  <= 1'b1;
      hot_p_q  <= 1'b0;
      warn_p_q <= 1'b0;
    end else begin
      sync1_q  <= {temp_warning, temp_shutdown, dvs_pin, en_pin};
      sync2_q  <= sync1_q;
      scl_p_q  <= scl_s;
      sda_p_q  <= sda_s;
      hot_p_q  <= sync2_q[3];
      warn_p_q <= sync2_q[4];
    end
  end

  wire en_s     = sync2_q[1];
  wire dvs_s    = sync2_q[2];
  wire hot_s    = sync2_q[3];
  wire warn_s   = sync2_q[4];
  wire scl_rise = scl_s & ~scl_p_q;
  wire scl_fall = ~scl_s & scl_p_q;
  wire bus_start = scl_s & scl_p_q & sda_p_q & ~sda_s;
  wire bus_stop  = scl_s & scl_p_q & ~sda_p_q & sda_s;

  // Registers held outside the settings store.
  reg  [7:0] enable_q;
  reg  [7:0] pulldown_q;
  reg  [7:0] irq_mask_q;
  reg  [1:0] irq_flags_q;
  reg        restore_q;

  // Settings store for registers 0x00 to 0x07.
  reg  [7:0] ptr_q;
  reg        mem_we;
  reg  [7:0] mem_wdata;
  wire [7:0] mem_rdata;
  wire [63:0] set_bytes;

  pmu_setmem u_setmem (
    .clock     (clock),
    .rst       (rst),
    .restore   (restore_q),
    .wr_en     (mem_we),
    .addr      (ptr_q[2:0]),
    .wr_data   (mem_wdata),
    .rd_data   (mem_rdata),
    .all_bytes (set_bytes)
  );

  // Read mux for the byte at the pointer.
  reg [7:0] rd_byte;
  always @* begin
    case (ptr_q)
      `PMU_REG_ENABLE:   rd_byte = enable_q;
      `PMU_REG_PULLDOWN: rd_byte = pulldown_q;
      `PMU_REG_STATUS:   rd_byte = {6'h00, hot_s, warn_s}; // [R12] [R13]
      `PMU_REG_IRQ:      rd_byte = {6'h00, irq_flags_q};  // [R14] [R15]
      `PMU_REG_IRQ_MASK: rd_byte = irq_mask_q;
      default:           rd_byte = (ptr_q < 8'h08) ? mem_rdata : 8'h00;
    endcase
  end

  // Bus engine state.
  reg [2:0] bst_q;
  reg [1:0] kind_q;
  reg       rw_q;
  reg [3:0] cnt_q;
  reg [7:0] sh_q;
  reg       wr_strobe;
  reg       irq_read_done;

  // Serial engine: start, address match, pointer, data writes and reads.
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      bst_q         <= B_IDLE;
      kind_q        <= K_ADDR;
      rw_q          <= 1'b0;
      cnt_q         <= 4'h0;
      sh_q          <= 8'h00;
      ptr_q         <= 8'h00;
      sda_o         <= 1'b0;
      sda_oe        <= 1'b0;
      wr_strobe     <= 1'b0;
      irq_read_done <= 1'b0;
    end else begin
      wr_strobe     <= 1'b0;
      irq_read_done <= 1'b0;
      if (bus_start) begin
        bst_q  <= B_RX;
        kind_q <= K_ADDR;
        cnt_q  <= 4'h0;
        sda_oe <= 1'b0;
      end else if (bus_stop) begin
        bst_q  <= B_IDLE;
        sda_oe <= 1'b0;
      end else begin
        case (bst_q)
          B_RX: begin
            if (scl_rise) begin
              sh_q  <= {sh_q[6:0], sda_s};
              cnt_q <= cnt_q + 4'h1;
            end else if (scl_fall && cnt_q == 4'h8) begin
              cnt_q <= 4'h0;
              if (kind_q == K_ADDR && sh_q[7:1] != `PMU_SLAVE_ADDR) begin
                bst_q <= B_IDLE;
              end else begin
                bst_q  <= B_RACK;
                sda_oe <= 1'b1;
                if (kind_q == K_ADDR) begin
                  rw_q <= sh_q[0];
                end else if (kind_q == K_PTR) begin
                  ptr_q <= sh_q;
                end else begin
                  wr_strobe <= 1'b1;
                end
              end
            end
          end
          B_RACK: begin
            if (scl_fall) begin
              sda_oe <= 1'b0;
              if (kind_q == K_DATA) begin
                ptr_q <= ptr_q + 8'h01;
              end
              if (kind_q == K_ADDR && rw_q) begin
                bst_q  <= B_TX;
                sh_q   <= rd_byte;
                sda_oe <= ~rd_byte[7];
              end else begin
                bst_q  <= B_RX;
                kind_q <= (kind_q == K_ADDR) ? K_PTR : K_DATA;
              end
            end
          end
          B_TX: begin
            if (scl_rise) begin
              cnt_q <= cnt_q + 4'h1;
            end else if (scl_fall) begin
              if (cnt_q == 4'h8) begin
                sda_oe        <= 1'b0;
                bst_q         <= B_TACK;
                cnt_q         <= 4'h0;
                irq_read_done <= (ptr_q == `PMU_REG_IRQ); // [R16] [R17]
                ptr_q         <= ptr_q + 8'h01;
              end else begin
                sh_q   <= {sh_q[6:0], 1'b0};
                sda_oe <= ~sh_q[6];
              end
            end
          end
          B_TACK: begin
            if (scl_rise) begin
              sh_q[0] <= sda_s;
            end else if (scl_fall) begin
              if (!sh_q[0]) begin
                bst_q  <= B_TX;
                sh_q   <= rd_byte;
                sda_oe <= ~rd_byte[7];
              end else begin
                bst_q <= B_IDLE;
              end
            end
          end
          default: begin
            bst_q  <= B_IDLE;
            sda_oe <= 1'b0;
          end
        endcase
      end
    end
  end

  // Write decode: status, interrupt and reserved bits are not writable.
  always @* begin
    mem_we    = wr_strobe && (ptr_q < 8'h08);
    mem_wdata = sh_q;
    if (ptr_q == `PMU_REG_GENERAL) begin
      mem_wdata = sh_q & `PMU_GENERAL_WMASK; // [R21]
    end else if (ptr_q == `PMU_REG_BUCK_B) begin
      mem_wdata = sh_q & `PMU_BUCK_B_WMASK; // [R21]
    end
  end

  // Registers 0x08, 0x09, 0x0C and the sticky interrupt flags.
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      enable_q    <= `PMU_ENABLE_RESET;
      pulldown_q  <= `PMU_PULLDOWN_RESET;
      irq_mask_q  <= `PMU_MASK_RESET;
      irq_flags_q <= 2'b00;
    end else if (restore_q) begin
      enable_q    <= `PMU_ENABLE_RESET; // [R11]
      pulldown_q  <= `PMU_PULLDOWN_RESET;
      irq_mask_q  <= `PMU_MASK_RESET;
      irq_flags_q <= {hot_s & ~hot_p_q, warn_s & ~warn_p_q}; // [R20]
    end else begin
      if (wr_strobe && ptr_q == `PMU_REG_ENABLE) begin
        enable_q <= sh_q;
      end
      if (wr_strobe && ptr_q == `PMU_REG_PULLDOWN) begin
        pulldown_q <= sh_q & `PMU_PULLDOWN_WMASK; // [R21]
      end
      if (wr_strobe && ptr_q == `PMU_REG_IRQ_MASK) begin
        irq_mask_q <= sh_q & `PMU_MASK_WMASK; // [R21]
      end
      // A rising event in the clearing cycle still sets its flag.
      irq_flags_q[`PMU_BIT_WARN] <= (irq_flags_q[`PMU_BIT_WARN] & ~irq_read_done)
                                    | (warn_s & ~warn_p_q); // [R15] [R20] [R16]
      irq_flags_q[`PMU_BIT_SHUTDOWN] <= (irq_flags_q[`PMU_BIT_SHUTDOWN] & ~irq_read_done)
                                        | (hot_s & ~hot_p_q); // [R14] [R20] [R16]
    end
  end

  // Start-up step timer and power state machine.
  reg [1:0]  pst_q;
  reg [10:0] tick_q;
  reg [2:0]  step_q;
  localparam [31:0] STEP_SHORT = `PMU_STEP_SHORT_CYC;
  localparam [31:0] STEP_LONG  = `PMU_STEP_LONG_CYC;
  wire [10:0] step_cycles = set_bytes[`PMU_BIT_SHORT_STEP] ?
                            STEP_SHORT[10:0] : STEP_LONG[10:0]; // [R18]
  wire step_tick = (tick_q == step_cycles - 11'd1);

  // Delay code of output n: linear outputs in bytes 1..5, buck in byte 6.
  function [2:0] delay_of;
    input [63:0] bytes;
    input integer n;
    begin
      delay_of = bytes[8*(n+1)+5 +: 3];
    end
  endfunction

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      pst_q     <= P_STBY;
      tick_q    <= 11'd0;
      step_q    <= 3'd0;
      restore_q <= 1'b0;
    end else begin
      restore_q <= 1'b0;
      tick_q    <= (pst_q == P_START && !step_tick) ? tick_q + 11'd1 : 11'd0;
      case (pst_q)
        P_STBY: begin
          step_q <= 3'd0;
          if (hot_s) begin
            pst_q <= P_HOT;
          end else if (en_s) begin
            pst_q <= P_START;
          end
        end
        P_START: begin
          if (hot_s) begin
            pst_q <= P_HOT;
          end else if (!en_s) begin
            pst_q <= P_STBY;
          end else if (step_tick) begin
            if (step_q == `PMU_DELAY_LAST) begin
              pst_q <= P_IDLE;
            end else begin
              step_q <= step_q + 3'd1;
            end
          end
        end
        P_IDLE: begin
          if (hot_s) begin
            pst_q <= P_HOT;
          end else if (!en_s) begin
            pst_q <= P_STBY;
          end
        end
        P_HOT: begin
          step_q <= 3'd0;
          if (!hot_s && en_s) begin
            restore_q <= ~pulldown_q[`PMU_BIT_RETAIN]; // [R11]
            pst_q     <= P_START; // [R10]
          end
        end
        default: begin
          pst_q <= P_STBY;
        end
      endcase
    end
  end

  // Output controls, all registered.
  integer k;
  reg [4:0] sel_code;
  always @* begin
    sel_code = ((set_bytes[`PMU_BIT_PIN_VSEL]) ? dvs_s : enable_q[`PMU_BIT_VSEL]) ?
               set_bytes[8*`PMU_REG_BUCK_A +: 5] : set_bytes[8*`PMU_REG_BUCK_B +: 5]; // [R8]
  end

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      output_on              <= 6'h00;
      discharge_on           <= 6'h00;
      buck_voltage_code      <= 5'h00;
      buck_feedback_external <= 1'b1; // Code zero after reset selects the divider.
      buck_forced_pwm        <= 1'b0;
      sleep_active           <= 1'b0;
      irq_n                  <= 1'b1;
    end else begin
      for (k = 0; k < 6; k = k + 1) begin
        if (pst_q == P_IDLE) begin
          output_on[k] <= enable_q[k]; // [R6]
        end else if (pst_q == P_START && !restore_q) begin // Old settings must not start anything.
          output_on[k] <= enable_q[k] && delay_of(set_bytes, k) != `PMU_DELAY_NEVER
                          && delay_of(set_bytes, k) <= step_q; // [R2] [R3] [R5]
        end else begin
          output_on[k] <= 1'b0;
        end
      end
      discharge_on           <= pulldown_q[5:0]; // [R9]
      buck_voltage_code      <= sel_code; // [R1]
      buck_feedback_external <= (sel_code == 5'h00); // [R1]
      buck_forced_pwm        <= set_bytes[8*`PMU_REG_BUCK_B + `PMU_BIT_FORCE_PWM]; // [R4]
      sleep_active           <= set_bytes[`PMU_BIT_PIN_SLEEP] ? ~dvs_s
                                : enable_q[`PMU_BIT_SLEEP_REQ]; // [R7]
      irq_n                  <= ~|(irq_flags_q & ~irq_mask_q[1:0]); // [R19] [R17]
    end
  end

endmodule

// ==== core/pmu_consts.vh ====
// Constants for the power-management control register bank.
`ifndef PMU_CONSTS_VH
`define PMU_CONSTS_VH

// Two-wire bus slave address.
`define PMU_SLAVE_ADDR     7'h7D

// Register pointers.
`define PMU_REG_GENERAL    8'h00
`define PMU_REG_BUCK_A     8'h06
`define PMU_REG_BUCK_B     8'h07
`define PMU_REG_ENABLE     8'h08
`define PMU_REG_PULLDOWN   8'h09
`define PMU_REG_STATUS     8'h0A
`define PMU_REG_IRQ        8'h0B
`define PMU_REG_IRQ_MASK   8'h0C

// Restore values of the settings registers 0x00 to 0x07, packed low byte first; reset clears them to zero.
`define PMU_SET_DEFAULTS   64'h05E5FF636C757D01
`define PMU_ENABLE_RESET   8'h8F
`define PMU_PULLDOWN_RESET 8'h3F
`define PMU_MASK_RESET     8'h03

// Writable bits of registers with reserved positions.
`define PMU_GENERAL_WMASK  8'h07
`define PMU_BUCK_B_WMASK   8'h3F
`define PMU_PULLDOWN_WMASK 8'hBF
`define PMU_MASK_WMASK     8'h03

// Field positions.
`define PMU_BIT_SHORT_STEP 0
`define PMU_BIT_PIN_SLEEP  1
`define PMU_BIT_PIN_VSEL   2
`define PMU_BIT_FORCE_PWM  5
`define PMU_BIT_SLEEP_REQ  6
`define PMU_BIT_VSEL       7
`define PMU_BIT_RETAIN     7
`define PMU_BIT_WARN       0
`define PMU_BIT_SHUTDOWN   1

// Start-up delay codes.
`define PMU_DELAY_NEVER    3'h7
`define PMU_DELAY_LAST     3'h6

// Start-up time step.
`define PMU_CLK_KHZ        20000
`define PMU_STEP_SHORT_NS  25000
`define PMU_STEP_LONG_NS   50000
`define PMU_STEP_SHORT_CYC ((`PMU_STEP_SHORT_NS * `PMU_CLK_KHZ) / 1000000)
`define PMU_STEP_LONG_CYC  ((`PMU_STEP_LONG_NS * `PMU_CLK_KHZ) / 1000000)

`endif

// ==== core/pmu_setmem.v ====
// Eight-byte settings store with registered read data and default restore.
`timescale 1ns/1ns
`include "pmu_consts.vh"

module pmu_setmem (
  input  wire        clock,
  input  wire        rst,
  input  wire        restore,
  input  wire        wr_en,
  input  wire [2:0]  addr,
  input  wire [7:0]  wr_data,
  output reg  [7:0]  rd_data,
  output wire [63:0] all_bytes
);

  localparam [63:0] DEFAULTS = `PMU_SET_DEFAULTS;

  reg [7:0] mem_q [0:7];
  integer   i;

  // Storage: reset clears every byte, restore loads the defaults, a write stores one byte.
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      for (i = 0; i < 8; i = i + 1) begin
        mem_q[i] <= 8'h00;
      end
      rd_data <= 8'h00;
    end else begin
      if (restore) begin
        for (i = 0; i < 8; i = i + 1) begin
          mem_q[i] <= DEFAULTS[8*i +: 8];
        end
      end else if (wr_en) begin
        mem_q[addr] <= wr_data;
      end
      rd_data <= mem_q[addr];
    end
  end

  // Parallel view of every byte for the control logic.
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : gen_flat
      assign all_bytes[8*g +: 8] = mem_q[g];
    end
  endgenerate

endmodule

// ==== sim/pmu_host_model.sv ====
// Bus host model that bit-bangs the two-wire register bus at a 400 ns bit period.
`timescale 1ns/1ns
`include "pmu_consts.vh"

module pmu_host_model (
  input  wire clock,
  input  wire sda_oe,
  output reg  scl,
  output wire sda_i
);
  reg sda_q;

  // Open-drain wire with a pull-up: it reads high unless a party pulls it low.
  assign sda_i = sda_q & ~sda_oe;

  // The bus idles with both lines released.
  initial begin
    scl = 1'b1;
    sda_q = 1'b1;
  end

  // Two system clocks make a quarter of a bus bit.
  task pause;
    repeat (2) @(posedge clock);
  endtask

  // One bus bit: data is set while the clock is low and sampled late in the high half.
  task bit_io(input d, output r);
    sda_q <= d;
    pause;
    scl <= 1'b1;
    pause;
    @(negedge clock) r = sda_i;
    pause;
    scl <= 1'b0;
    pause;
  endtask

  // Start, also used as repeated start from a low clock.
  task start;
    pause;
    sda_q <= 1'b1;
    pause;
    scl <= 1'b1;
    pause;
    sda_q <= 1'b0;
    pause;
    scl <= 1'b0;
    pause;
  endtask

  // Stop leaves both lines released.
  task stop;
    sda_q <= 1'b0;
    pause;
    scl <= 1'b1;
    pause;
    sda_q <= 1'b1;
    pause;
  endtask

  // One byte MSB first, then the ninth bit; ok is high when the ninth bit was pulled low.
  task xfer(input [7:0] tx, output [7:0] rx, output ok);
    integer i;
    reg     r;
    for (i = 7; i >= 0; i = i - 1) begin
      bit_io(tx[i], r);
      rx[i] = r;
    end
    bit_io(1'b1, r);
    ok = ~r;
  endtask

  // Pointer then one data byte.
  task wr(input [7:0] p, input [7:0] d, output ok);
    reg [7:0] x;
    reg       a;
    reg       b;
    reg       c;
    start;
    xfer({`PMU_SLAVE_ADDR, 1'b0}, x, a);
    xfer(p, x, b);
    xfer(d, x, c);
    stop;
    ok = a & b & c;
  endtask

  // Pointer, repeated start, one byte read and ended with a not-acknowledge.
  task rd(input [7:0] p, output [7:0] d, output ok);
    reg [7:0] x;
    reg       a;
    reg       b;
    reg       c;
    start;
    xfer({`PMU_SLAVE_ADDR, 1'b0}, x, a);
    xfer(p, x, b);
    start;
    xfer({`PMU_SLAVE_ADDR, 1'b1}, x, c);
    xfer(8'hFF, d, x[0]);
    stop;
    ok = a & b & c;
  endtask
endmodule

// ==== sim/pmu_regbank_asserts.sv ====
// Concurrent checks on the ports of the control register bank.
`timescale 1ns/1ns

module pmu_regbank_asserts (
  input wire       clock,
  input wire       rst,
  input wire       scl,
  input wire       sda_i,
  input wire       sda_o,
  input wire       sda_oe,
  input wire       en_pin,
  input wire       dvs_pin,
  input wire       temp_shutdown,
  input wire       temp_warning,
  input wire       irq_n,
  input wire [4:0] buck_voltage_code,
  input wire       buck_feedback_external,
  input wire       buck_forced_pwm,
  input wire       sleep_active,
  input wire [5:0] output_on,
  input wire [5:0] discharge_on
);
  reg [5:0] calm_q;

  // Cycles since reset or shutdown; settings may move without bus traffic only shortly after those.
  always @(posedge clock or posedge rst) begin
    if (rst)
      calm_q <= 6'h00;
    else if (temp_shutdown)
      calm_q <= 6'h00;
    else if (calm_q != 6'h3F)
      calm_q <= calm_q + 6'h01;
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  sequence s_standby;
    !en_pin [*6];
  endsequence

  sequence s_hot;
    temp_shutdown [*6];
  endsequence

  a_fb_zero_code: assert property (buck_feedback_external == (buck_voltage_code == 5'h00))
    else $error("feedback select disagrees with code");
  a_standby_all_off: assert property (s_standby |-> output_on == 6'h00)
    else $error("output on while enable pin low");
  a_hot_all_off: assert property (s_hot |-> output_on == 6'h00)
    else $error("output on during thermal shutdown");
  a_discharge_by_write: assert property ($changed(discharge_on) |-> sda_oe || calm_q < 6'h28)
    else $error("discharge changed without a write");
  a_pwm_by_write: assert property ($changed(buck_forced_pwm) |-> sda_oe || calm_q < 6'h28)
    else $error("forced switching changed without a write");
  a_code_cause: assert property ($changed(buck_voltage_code) |->
    sda_oe || calm_q < 6'h28 || dvs_pin != $past(dvs_pin, 6))
    else $error("buck code changed without cause");
  a_sleep_cause: assert property ($changed(sleep_active) |->
    sda_oe || calm_q < 6'h28 || dvs_pin != $past(dvs_pin, 6))
    else $error("sleep changed without cause");
  a_drive_value_low: assert property (sda_o == 1'b0)
    else $error("data line drive value not low");
  a_irq_on_event: assert property ($fell(irq_n) |-> temp_warning || temp_shutdown)
    else $error("interrupt without a thermal event");
endmodule

bind pmu_regbank pmu_regbank_asserts pmu_regbank_asserts_i (
  .clock(clock), .rst(rst), .scl(scl), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe),
  .en_pin(en_pin), .dvs_pin(dvs_pin), .temp_shutdown(temp_shutdown), .temp_warning(temp_warning),
  .irq_n(irq_n), .buck_voltage_code(buck_voltage_code), .buck_feedback_external(buck_feedback_external),
  .buck_forced_pwm(buck_forced_pwm), .sleep_active(sleep_active), .output_on(output_on),
  .discharge_on(discharge_on));

// ==== sim/pmu_regbank_bench.sv ====
// Self-checking bench for the control register bank.
`timescale 1ns/1ns
`include "pmu_consts.vh"

module pmu_regbank_bench;
  localparam integer STEP = `PMU_STEP_SHORT_CYC;
  reg        clock;
  reg        rst;
  reg        en_pin;
  reg        dvs_pin;
  reg        temp_shutdown;
  reg        temp_warning;
  reg  [7:0] got;
  reg        ok;
  wire       scl;
  wire       sda_i;
  wire       sda_oe;
  wire       irq_n;
  wire [4:0] code;
  wire       fb_ext;
  wire       pwm;
  wire       sleep;
  wire [5:0] output_on;
  wire [5:0] discharge_on;
  integer    n_errors;
  integer    n_compared;
  integer    r;

  // Device and bus host.
  pmu_regbank pmu_regbank_i (.clock(clock), .rst(rst), .scl(scl), .sda_i(sda_i), .sda_o(), .sda_oe(sda_oe),
    .en_pin(en_pin), .dvs_pin(dvs_pin), .temp_shutdown(temp_shutdown), .temp_warning(temp_warning),
    .irq_n(irq_n), .buck_voltage_code(code), .buck_feedback_external(fb_ext), .buck_forced_pwm(pwm),
    .sleep_active(sleep), .output_on(output_on), .discharge_on(discharge_on));
  pmu_host_model pmu_host_model_i (.clock(clock), .sda_oe(sda_oe), .scl(scl), .sda_i(sda_i));

  // System clock of 50 ns.
  always #25 clock = ~clock;

  task give_verdict;
    $display("Compared %0d, mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task check(input [7:0] seen, input [7:0] exp);
    n_compared = n_compared + 1;
    if (seen !== exp) begin
      n_errors = n_errors + 1;
      $display("BAD at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task tick(input integer n);
    repeat (n) @(posedge clock);
  endtask

  // Waits and then lands on a falling edge so that outputs are settled.
  task look(input integer n);
    repeat (n) @(posedge clock);
    @(negedge clock);
  endtask

  task wr(input [7:0] p, input [7:0] d);
    pmu_host_model_i.wr(p, d, ok);
    check({7'h00, ok}, 8'h01);
  endtask

  task rd(input [7:0] p, input [7:0] exp);
    pmu_host_model_i.rd(p, got, ok);
    check({7'h00, ok}, 8'h01);
    check(got, exp);
  endtask

  // Bounded wait for the outputs to reach a pattern.
  task wait_on(input [5:0] exp);
    integer k;
    k = 0;
    while (output_on !== exp && k < 6000) begin
      @(negedge clock);
      k = k + 1;
    end
    check({2'b00, output_on}, {2'b00, exp});
    if (k == 6000)
      give_verdict;
  endtask

  // Main sequence.
  initial begin
    clock = 1'b0;
    rst = 1'b1;
    en_pin = 1'b0;
    dvs_pin = 1'b0;
    temp_shutdown = 1'b0;
    temp_warning = 1'b0;
    n_errors = 0;
    n_compared = 0;
    tick(10);
    rst <= 1'b0;
    tick(4);
    rd(8'h08, 8'h8F);
    rd(8'h09, 8'h3F);
    rd(8'h0C, 8'h03);
    rd(8'h0A, 8'h00);
    rd(8'h0B, 8'h00);
    rd(8'h0D, 8'h00);
    check({2'b00, discharge_on}, 8'h3F);
    $display("Test reset values done");
    wr(8'h0A, 8'hFF);
    wr(8'h0B, 8'hFF);
    wr(8'h00, 8'hFF);
    wr(8'h09, 8'hFF);
    rd(8'h0A, 8'h00);
    rd(8'h0B, 8'h00);
    rd(8'h00, 8'h07);
    rd(8'h09, 8'hBF);
    wr(8'h09, 8'h15);
    wr(8'h00, 8'h00);
    look(2);
    check({2'b00, discharge_on}, 8'h15);
    $display("Test write masks done");
    wr(8'h06, 8'h10);
    wr(8'h07, 8'h25);
    look(2);
    check({3'b000, code}, 8'h10);
    check({6'h00, fb_ext, pwm}, 8'h01);
    wr(8'h08, 8'h0F);
    look(2);
    check({3'b000, code}, 8'h05);
    tick(1);
    dvs_pin <= 1'b1;
    wr(8'h00, 8'h04);
    look(2);
    check({3'b000, code}, 8'h10);
    wr(8'h07, 8'h00);
    tick(1);
    dvs_pin <= 1'b0;
    look(8);
    check({6'h00, fb_ext, pwm}, 8'h02);
    $display("Test buck select done");
    wr(8'h00, 8'h00);
    wr(8'h08, 8'h4F);
    look(2);
    check({7'h00, sleep}, 8'h01);
    tick(1);
    dvs_pin <= 1'b1;
    wr(8'h00, 8'h02);
    look(2);
    check({7'h00, sleep}, 8'h00);
    tick(1);
    dvs_pin <= 1'b0;
    look(8);
    check({7'h00, sleep}, 8'h01);
    $display("Test sleep done");
    wr(8'h00, 8'h01);
    wr(8'h01, 8'h40);
    wr(8'h02, 8'hE0);
    wr(8'h03, 8'hC0);
    wr(8'h04, 8'h00);
    wr(8'h05, 8'h20);
    wr(8'h06, 8'h10);
    wr(8'h08, 8'hAD);
    look(2);
    check({2'b00, output_on}, 8'h00);
    tick(1);
    en_pin <= 1'b1;
    look(STEP / 2);
    check({2'b00, output_on}, 8'h28);
    look(STEP * 2);
    check({2'b00, output_on}, 8'h29);
    look(STEP * 3);
    check({2'b00, output_on}, 8'h29);
    look(STEP);
    check({2'b00, output_on}, 8'h2D);
    look(STEP);
    wr(8'h08, 8'h81);
    look(2);
    check({2'b00, output_on}, 8'h01);
    $display("Test start-up done");
    tick(1);
    temp_warning <= 1'b1;
    look(8);
    check({7'h00, irq_n}, 8'h01);
    rd(8'h0A, 8'h01);
    rd(8'h0B, 8'h01);
    rd(8'h0B, 8'h00);
    wr(8'h0C, 8'h00);
    tick(1);
    temp_warning <= 1'b0;
    tick(8);
    temp_warning <= 1'b1;
    tick(8);
    temp_warning <= 1'b0;
    look(8);
    check({7'h00, irq_n}, 8'h00);
    rd(8'h0B, 8'h01);
    look(2);
    check({7'h00, irq_n}, 8'h01);
    rd(8'h0A, 8'h00);
    $display("Test interrupts done");
    for (r = 0; r < 2; r = r + 1) begin
      wr(8'h06, 8'h11);
      wr(8'h09, {r[0], 7'h15});
      tick(1);
      temp_shutdown <= 1'b1;
      look(8);
      check({2'b00, output_on}, 8'h00);
      rd(8'h0A, 8'h02);
      rd(8'h0B, 8'h02);
      tick(1);
      temp_shutdown <= 1'b0;
      wait_on(6'h0F);
      rd(8'h06, (r == 1) ? 8'h11 : 8'hE5);
    end
    $display("Test thermal restart done");
    give_verdict;
  end
endmodule
